// ### rtl/fdp3_pkg.sv
// constants for the third fractional divider parameter register bank
package fdp3_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    // ==========================================================
    localparam int unsigned NUM_REGS = 9;
    localparam logic [6:0] IDX_DIV3_DENOM_MID         = 7'h42;
    localparam logic [6:0] IDX_DIV3_DENOM_LOW         = 7'h43;
    localparam logic [6:0] IDX_DIV3_POSTDIV_INT_HIGH  = 7'h44;
    localparam logic [6:0] IDX_DIV3_INT_MID           = 7'h45;
    localparam logic [6:0] IDX_DIV3_INT_LOW           = 7'h46;
    localparam logic [6:0] IDX_DIV3_FRAC_HIGH_NIBBLES = 7'h47;
    localparam logic [6:0] IDX_DIV3_NUMER_MID         = 7'h48;
    localparam logic [6:0] IDX_DIV3_NUMER_LOW         = 7'h49;
    localparam logic [6:0] IDX_DIV4_DENOM_MID         = 7'h4A;
    localparam logic [6:0] IDX_FIRST                  = IDX_DIV3_DENOM_MID;

    // slot numbers inside the local array
    localparam int unsigned SLOT_DENOM_MID  = 0;
    localparam int unsigned SLOT_DENOM_LOW  = 1;
    localparam int unsigned SLOT_POST_INT   = 2;
    localparam int unsigned SLOT_INT_MID    = 3;
    localparam int unsigned SLOT_INT_LOW    = 4;
    localparam int unsigned SLOT_FRAC_HIGH  = 5;
    localparam int unsigned SLOT_NUMER_MID  = 6;
    localparam int unsigned SLOT_NUMER_LOW  = 7;
    localparam int unsigned SLOT_D4_DENOM   = 8;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int unsigned POSTDIV_LSB   = 4;
    localparam int unsigned POSTDIV_MSB   = 6;
    localparam int unsigned INT_HIGH_LSB  = 0;
    localparam int unsigned INT_HIGH_MSB  = 1;
    localparam int unsigned NUMER_HI_LSB  = 0;
    localparam int unsigned NUMER_HI_MSB  = 3;
    localparam int unsigned DENOM_HI_LSB  = 4;
    localparam int unsigned DENOM_HI_MSB  = 7;

    // ==========================================================
    // widths
    // ==========================================================
    localparam int unsigned REG_W      = 8;
    localparam int unsigned INT_W      = 18;
    localparam int unsigned FRAC_W     = 20;
    localparam int unsigned POSTDIV_W  = 3;
    localparam int unsigned PDCNT_W    = 7;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned ADDR_W     = 12;

    localparam logic [1:0] WORD_ALIGN  = 2'h0;

    // full register bank state (bytes, bus response, post-divider), held as one packed struct
    typedef struct packed {
        logic [NUM_REGS-1:0][REG_W-1:0] regs;
        logic                           pready;
        logic                           pslverr;
        logic [DATA_W-1:0]              prdata;
        logic [PDCNT_W-1:0]             pd_cnt;
        logic                           out_tick;
    } fdp3_state_t;

endpackage : fdp3_pkg

// ### rtl/fdp3_regs.sv
// apb register bank and post-divider for the third fractional divider
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// (R01) The third output is divided by two to the power of the 3-bit code in bits 6:4 of the post-divider register, 000b giving 1 and 111b giving 128.
// (R02) The 18-bit integer parameter is bits 1:0 of the post-divider register, then the integer middle byte, then the integer low byte.
// (R03) The 20-bit numerator is the low nibble of the high-nibbles register, then the numerator middle byte, then the numerator low byte.
// (R04) The 20-bit denominator is the high nibble of the high-nibbles register, then the denominator middle byte, then the denominator low byte.
// (R05) Bits 15:8 of the fourth divider's denominator are the full byte of its read-write register.
// (R06) Parameter bytes are not initialised by reset, so software writes all of them before trusting the output.
// (R07) Software writes zero to bit 7 and bits 3:2 of the post-divider register, and the divider ignores them.
module fdp3_regs #(
    parameter int unsigned ADDR_W = fdp3_pkg::ADDR_W
) (
    input  wire logic                          CORE_CLK,
    input  wire logic                          SRST,
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [ADDR_W-1:0]             PADDR,
    input  wire logic [fdp3_pkg::DATA_W-1:0]   PWDATA,
    input  wire logic [3:0]                    PSTRB,
    output logic      [fdp3_pkg::DATA_W-1:0]   PRDATA,
    output logic                               PREADY,
    output logic                               PSLVERR,
    input  wire logic                          SYNTH3_TICK,
    output logic                               OUT3_TICK,
    output logic      [fdp3_pkg::POSTDIV_W-1:0] OUT3_POST_DIVIDER_CODE,
    output logic      [fdp3_pkg::INT_W-1:0]    DIV3_INTEGER_PARAM,
    output logic      [fdp3_pkg::FRAC_W-1:0]   DIV3_FRAC_NUMERATOR,
    output logic      [fdp3_pkg::FRAC_W-1:0]   DIV3_FRAC_DENOMINATOR,
    output logic      [fdp3_pkg::REG_W-1:0]    DIV4_FRAC_DENOMINATOR_MID
);

    // ==========================================================
    // helpers
    // ==========================================================

    // word address to slot; valid flag high only for a mapped, aligned word
    function automatic logic [4:0] addr_slot(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] idx;
        logic [4:0]        res;
        idx = a[ADDR_W-1:2];
        res = 5'h00;
        if (a[1:0] != fdp3_pkg::WORD_ALIGN) begin
            res = 5'h00;
        end else if (idx >= (ADDR_W-2)'(fdp3_pkg::IDX_FIRST) &&
                     idx <= (ADDR_W-2)'(fdp3_pkg::IDX_DIV4_DENOM_MID)) begin
            res = {1'b1, 4'(idx - (ADDR_W-2)'(fdp3_pkg::IDX_FIRST))};
        end else begin
            res = 5'h00;
        end
        return res;
    endfunction

    // terminal count for divide by two to the code
    function automatic logic [fdp3_pkg::PDCNT_W-1:0] pd_last(
        input logic [fdp3_pkg::POSTDIV_W-1:0] code
    );
        logic [fdp3_pkg::PDCNT_W:0] one_hot;
        one_hot = (fdp3_pkg::PDCNT_W+1)'(1) << code;
        return fdp3_pkg::PDCNT_W'(one_hot - (fdp3_pkg::PDCNT_W+1)'(1));
    endfunction

    // ==========================================================
    // state
    // ==========================================================
    fdp3_pkg::fdp3_state_t q;
    fdp3_pkg::fdp3_state_t d;

    logic                              setup_phase;
    logic                              access_done;
    logic [4:0]                        slot_hit;
    logic [3:0]                        slot;
    logic [fdp3_pkg::POSTDIV_W-1:0]    code;
    logic [fdp3_pkg::PDCNT_W-1:0]      last;

    // only bits 6:4 steer the divider; bit 7 and 3:2 are don't-care
    assign code = q.regs[fdp3_pkg::SLOT_POST_INT][fdp3_pkg::POSTDIV_MSB:fdp3_pkg::POSTDIV_LSB]; // [R01] [R07]
    assign last = pd_last(code); // [R01]

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        d           = q;
        setup_phase = PSEL && !PENABLE;
        access_done = PSEL && PENABLE && q.pready;
        slot_hit    = addr_slot(PADDR);
        slot        = slot_hit[3:0];

        // answer one cycle after setup: one wait-free access cycle
        d.pready  = setup_phase;
        d.pslverr = setup_phase && !slot_hit[4];
        d.prdata  = '0;
        if (setup_phase && slot_hit[4] && !PWRITE) begin
            d.prdata = {{(fdp3_pkg::DATA_W-fdp3_pkg::REG_W){1'b0}}, q.regs[slot]};
        end

        // byte write on the access edge; parameters have no reset value
        // writes are dropped while reset is held, even if a transfer straddles it
        if (access_done && PWRITE && slot_hit[4] && PSTRB[0] && !SRST) begin
            d.regs[slot] = PWDATA[fdp3_pkg::REG_W-1:0]; // [R05] [R06]
        end

        // post-divider: count source ticks, emit one per 2^code ticks
        d.out_tick = 1'b0;
        if (SYNTH3_TICK) begin
            if (q.pd_cnt >= last) begin
                d.pd_cnt   = '0;
                d.out_tick = 1'b1; // [R01]
            end else begin
                d.pd_cnt = q.pd_cnt + fdp3_pkg::PDCNT_W'(1);
            end
        end

        // control state only; parameter bytes stay as they were
        if (SRST) begin
            d.pready   = 1'b0;
            d.pslverr  = 1'b0;
            d.prdata   = '0;
            d.pd_cnt   = '0;
            d.out_tick = 1'b0; // [R06]
        end
    end

    // single register stage
    always_ff @(posedge CORE_CLK) begin
        q <= d;
    end

    // ==========================================================
    // outputs, all taken from flip-flops
    // ==========================================================
    assign PRDATA  = q.prdata;
    assign PREADY  = q.pready;
    assign PSLVERR = q.pslverr;
    assign OUT3_TICK = q.out_tick;
    assign OUT3_POST_DIVIDER_CODE = code; // [R01]

    // integer part from three bytes
    assign DIV3_INTEGER_PARAM = {
        q.regs[fdp3_pkg::SLOT_POST_INT][fdp3_pkg::INT_HIGH_MSB:fdp3_pkg::INT_HIGH_LSB],
        q.regs[fdp3_pkg::SLOT_INT_MID],
        q.regs[fdp3_pkg::SLOT_INT_LOW]
    }; // [R02]

    // numerator from the low nibble and two bytes
    assign DIV3_FRAC_NUMERATOR = {
        q.regs[fdp3_pkg::SLOT_FRAC_HIGH][fdp3_pkg::NUMER_HI_MSB:fdp3_pkg::NUMER_HI_LSB],
        q.regs[fdp3_pkg::SLOT_NUMER_MID],
        q.regs[fdp3_pkg::SLOT_NUMER_LOW]
    }; // [R03]

    // denominator from the high nibble and two bytes
    assign DIV3_FRAC_DENOMINATOR = {
        q.regs[fdp3_pkg::SLOT_FRAC_HIGH][fdp3_pkg::DENOM_HI_MSB:fdp3_pkg::DENOM_HI_LSB],
        q.regs[fdp3_pkg::SLOT_DENOM_MID],
        q.regs[fdp3_pkg::SLOT_DENOM_LOW]
    }; // [R04]

    assign DIV4_FRAC_DENOMINATOR_MID = q.regs[fdp3_pkg::SLOT_D4_DENOM]; // [R05]

endmodule // fdp3_regs

`default_nettype wire

// ### testbench/fdp3_regs_properties.sv
// assertions on the ports of the divider parameter register bank
`timescale 1ns/100ps
`default_nettype none
module fdp3_regs_properties (
    input wire logic        CORE_CLK,
    input wire logic        SRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        SYNTH3_TICK,
    input wire logic        OUT3_TICK,
    input wire logic [2:0]  OUT3_POST_DIVIDER_CODE,
    input wire logic [17:0] DIV3_INTEGER_PARAM,
    input wire logic [19:0] DIV3_FRAC_NUMERATOR,
    input wire logic [19:0] DIV3_FRAC_DENOMINATOR,
    input wire logic [7:0]  DIV4_FRAC_DENOMINATOR_MID
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    // a committed write: strobe on and no error
    wire logic wr = PSEL & PENABLE & PREADY & PWRITE & PSTRB[0] & ~PSLVERR;
    sequence s_wr(a); wr && PADDR == a; endsequence
    sequence s_setup; PSEL && !PENABLE; endsequence
    // ==============================
    // bus handshake and field mapping
    a_ready_next: assert property (s_setup |=> PREADY ##1 !PREADY)
        else $error("ready not one cycle after setup");
    a_code_field: assert property (s_wr(12'h110) |=> OUT3_POST_DIVIDER_CODE == $past(PWDATA[6:4]))
        else $error("post divider code wrong");
    a_int_high: assert property (s_wr(12'h110) |=> DIV3_INTEGER_PARAM[17:16] == $past(PWDATA[1:0]))
        else $error("integer high bits wrong");
    a_frac_high: assert property (s_wr(12'h11C) |=>
        DIV3_FRAC_NUMERATOR[19:16] == $past(PWDATA[3:0])
        && DIV3_FRAC_DENOMINATOR[19:16] == $past(PWDATA[7:4]))
        else $error("fraction high nibbles wrong");
    a_denom_mid: assert property (s_wr(12'h108) |=> DIV3_FRAC_DENOMINATOR[15:8] == $past(PWDATA[7:0]))
        else $error("denominator middle byte wrong");
    a_div4_byte: assert property (s_wr(12'h128) |=> DIV4_FRAC_DENOMINATOR_MID == $past(PWDATA[7:0]))
        else $error("fourth divider byte wrong");
    // ==============================
    // post divider pulses
    a_tick_div1: assert property (OUT3_POST_DIVIDER_CODE == 3'h0 && SYNTH3_TICK |=> OUT3_TICK)
        else $error("divide by one missed a tick");
    a_tick_cause: assert property (OUT3_TICK |-> $past(SYNTH3_TICK))
        else $error("output pulse without source tick");
endmodule // fdp3_regs_properties
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the divider parameter register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        CORE_CLK = 1'b0, SRST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic        SYNTH3_TICK = 1'b0, PREADY, PSLVERR, OUT3_TICK;
    logic [11:0] PADDR = 12'h0;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic [3:0]  PSTRB = 4'h0;
    logic [2:0]  OUT3_POST_DIVIDER_CODE;
    logic [17:0] DIV3_INTEGER_PARAM;
    logic [19:0] DIV3_FRAC_NUMERATOR, DIV3_FRAC_DENOMINATOR;
    logic [7:0]  DIV4_FRAC_DENOMINATOR_MID, m [9];
    logic [32:0] q [$];
    int          fail_count = 0, n_compared = 0, n_out = 0, k, s;
    always #50 CORE_CLK = ~CORE_CLK;
    fdp3_regs u_dut (.CORE_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
        .PRDATA, .PREADY, .PSLVERR, .SYNTH3_TICK, .OUT3_TICK, .OUT3_POST_DIVIDER_CODE,
        .DIV3_INTEGER_PARAM, .DIV3_FRAC_NUMERATOR, .DIV3_FRAC_DENOMINATOR,
        .DIV4_FRAC_DENOMINATOR_MID);
    // ==============================
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // monitor takes the oldest note at each completed transfer
    always @(posedge CORE_CLK) begin
        if (PSEL && PENABLE && PREADY === 1'b1) chk({PSLVERR, PRDATA}, q.pop_front());
        if (OUT3_TICK === 1'b1) n_out <= n_out + 1;
    end
    // request held until ready is seen, one idle edge after to avoid a double drive
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
                       input logic st, input logic [32:0] e);
        int g;
        g = 0;
        q.push_back(e);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h0, d};
        PSTRB <= {3'h0, st};
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do @(posedge CORE_CLK); while (PREADY !== 1'b1 && ++g < 20);
        if (g >= 20) fail_count++;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    task automatic wr(input int i, input logic [7:0] d);
        m[i] = d;
        apb(12'h108 + 12'(i * 4), 1'b1, d, 1'b1, 33'h0);
    endtask
    task automatic rd(input int i);
        apb(12'h108 + 12'(i * 4), 1'b0, 8'h0, 1'b1, {25'h0, m[i]});
    endtask
    // lone tick; three edges so the pulse count has settled on return
    task automatic tick;
        SYNTH3_TICK <= 1'b1;
        @(posedge CORE_CLK);
        SYNTH3_TICK <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
    endtask
    task automatic close_out;
        // a note never answered is a missed transfer
        fail_count += q.size();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==============================
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        fail_count++;
        close_out();
    end
    initial begin
        s = $urandom(79);
        repeat (5) @(posedge CORE_CLK);
        SRST <= 1'b0;
        chk({31'h0, PREADY, PSLVERR}, 33'h0);
        // every byte written before use, reserved bits kept zero
        repeat (2) begin
            for (int i = 0; i < 9; i++) wr(i, 8'($urandom) & ((i == 2) ? 8'h73 : 8'hFF));
            for (int i = 0; i < 9; i++) rd(i);
            chk({15'h0, DIV3_INTEGER_PARAM}, {15'h0, m[2][1:0], m[3], m[4]});
            chk({13'h0, DIV3_FRAC_NUMERATOR}, {13'h0, m[5][3:0], m[6], m[7]});
            chk({13'h0, DIV3_FRAC_DENOMINATOR}, {13'h0, m[5][7:4], m[0], m[1]});
            chk({25'h0, DIV4_FRAC_DENOMINATOR_MID}, {25'h0, m[8]});
            chk({30'h0, OUT3_POST_DIVIDER_CODE}, {30'h0, m[2][6:4]});
        end
        $display("register round trip done");
        // refused places and a write with its strobe off leave the bytes alone
        apb(12'h12C, 1'b1, 8'h5A, 1'b1, {1'b1, 32'h0});
        apb(12'h104, 1'b0, 8'h0, 1'b1, {1'b1, 32'h0});
        apb(12'h109, 1'b1, 8'hA5, 1'b1, {1'b1, 32'h0});
        apb(12'h128, 1'b1, ~m[8], 1'b0, 33'h0);
        rd(8);
        rd(0);
        $display("refusal test done");
        // every code: sync on one pulse, then two full periods give two pulses
        for (int c = 0; c < 8; c++) begin
            wr(2, 8'(c << 4));
            k = n_out;
            for (int t = 0; t < 200 && n_out == k; t++) tick();
            k = n_out;
            repeat (2 << c) tick();
            chk(33'(n_out - k), 33'h2);
        end
        $display("post divider test done");
        close_out();
    end
endmodule // tb
bind fdp3_regs fdp3_regs_properties u_props (.CORE_CLK, .SRST, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PSTRB, .PREADY, .PSLVERR, .SYNTH3_TICK, .OUT3_TICK,
    .OUT3_POST_DIVIDER_CODE, .DIV3_INTEGER_PARAM, .DIV3_FRAC_NUMERATOR,
    .DIV3_FRAC_DENOMINATOR, .DIV4_FRAC_DENOMINATOR_MID);
`default_nettype wire
